//--- src/phy_mode_pkg.sv
// constants for the phy link mode configuration block
package phy_mode_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BYPASS = 8'h04;
  localparam logic [7:0] OFS_AUX = 8'h08;
  localparam logic [7:0] OFS_XOVER = 8'h0c;
  localparam logic [7:0] OFS_EXT3 = 8'h10;
  localparam logic [7:0] OFS_EEE = 8'h14;
  localparam logic [7:0] OFS_LADV = 8'h18;
  localparam logic [7:0] OFS_PADV = 8'h1c;
  localparam logic [7:0] OFS_WAKE = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // mode control fields
  localparam int MODE_DUPLEX = 0;
  localparam int MODE_SPD_LO = 1;
  localparam int MODE_AN_EN = 3;
  localparam int MODE_PDOWN = 4;
  localparam logic [4:0] MODE_RST = 5'h0d;
  // bypass control fields
  localparam int BYP_DIS_XOVER = 0;
  localparam int BYP_DIS_POL = 1;
  localparam int BYP_DIS_XFORCED = 2;
  // auxiliary control and status fields
  localparam int AUX_ENH_EN = 0;
  localparam int AUX_MDIX = 1;
  localparam int AUX_CDSWAP = 2;
  localparam int AUX_POL_LO = 3;
  localparam int AUX_SLEEP = 7;
  // extended control 3 fields
  localparam int EXT_IMPAIR_EN = 0;
  localparam int EXT_DS_EN = 1;
  localparam int EXT_DS_CNT_LO = 2;
  localparam int EXT_APPLY = 4;
  localparam logic [3:0] EXT_RST = 4'h6;
  localparam logic [2:0] DS_CNT_BASE = 3'h2;
  // eee control fields
  localparam int EEE_FORCE_GIG = 0;
  localparam int EEE_TEN_TE = 1;
  // low power advertisement bits
  localparam int ADV_100 = 1;
  localparam int ADV_1000 = 2;
  localparam logic [15:0] LADV_RST = 16'h0006;
  // crossover force field codes
  localparam logic [1:0] XF_AUTO = 2'h0;
  localparam logic [1:0] XF_MDI = 2'h2;
  localparam logic [1:0] XF_MDIX = 2'h3;
  // speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // suspend state codes
  localparam logic [1:0] SUSP_DEEPEST = 2'h2;
  // wake interval unit and default
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_UNIT_US = 1000;
  localparam logic [7:0] WAKE_RST = 8'h04;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : phy_mode_pkg

//--- src/phy_link_mode_config.sv
// phy link mode configuration: crossover, polarity, downshift, eee, power management
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module phy_link_mode_config
  import phy_mode_pkg::*;
#(
  parameter int TICK_CYC = WAKE_UNIT_US * 1000 / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // line side detection results
  input wire logic signal_detect,
  input wire logic link_up,
  input wire logic xover_detect,
  input wire logic cd_swap_detect,
  input wire logic [3:0] pair_pol_inv,
  input wire logic gig_attempt_fail,
  input wire logic partner_gig_capable,
  input wire logic pairs_cd_present,
  input wire logic [1:0] an_speed,
  input wire logic an_duplex,
  input wire logic [15:0] partner_lowpower_advert,
  // system state
  input wire logic [1:0] suspend_state,
  input wire logic power_event_mode,
  input wire logic nv_enh_default,
  // line side controls
  output logic mdix_sel,
  output logic swap_cd_sel,
  output logic [3:0] pol_correct,
  output logic [1:0] speed_out,
  output logic duplex_out,
  output logic gig_forced,
  output logic adv_1000,
  output logic power_down,
  output logic tx_amp_reduced,
  output logic lpi_enable,
  output logic phy_sleep,
  output logic flp_burst
);

  typedef enum logic [2:0] {
    EP_ACTIVE = 3'b001,
    EP_SLEEP = 3'b010,
    EP_WAKE = 3'b100
  } ep_state_t;

  // software registers
  logic [4:0] mode_r;
  logic [2:0] bypass_r;
  logic enh_en_r;
  logic [1:0] xforce_r;
  logic [3:0] ext3_r;
  logic [1:0] eee_r;
  logic [15:0] ladv_r;
  logic [7:0] wake_r;
  logic nv_loaded_r;
  // bus state
  logic aw_got_r, w_got_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  // block state
  logic [2:0] fail_cnt_r;
  logic downshift_r;
  ep_state_t ep_r;
  logic [31:0] tick_r;
  logic [7:0] units_r;
  // derived combinational values
  logic do_write, wr_hit, rd_take, rd_hit;
  logic [31:0] wmask, rd_val;
  logic [1:0] spd_nxt;
  logic auto_xover, enh_allowed;
  logic [2:0] ds_limit;

  assign do_write = aw_got_r && w_got_r && !bvalid;
  assign rd_take = arvalid && arready;
  assign ds_limit = ext3_r[EXT_DS_CNT_LO +: 2] + DS_CNT_BASE;
  assign enh_allowed = enh_en_r && (suspend_state != SUSP_DEEPEST);

  // byte lane mask from the held strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wstrb_r[i]}};
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        waddr_r <= awaddr[7:0];
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // ready flags and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= !aw_got_r && !(awvalid && awready) && !bvalid && !do_write;
      wready <= !w_got_r && !(wvalid && wready) && !bvalid && !do_write;
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // address decode for writes
  always_comb begin
    unique case (waddr_r)
      OFS_MODE, OFS_BYPASS, OFS_AUX, OFS_XOVER, OFS_EXT3, OFS_EEE, OFS_LADV, OFS_WAKE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // software register writes, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_RST;
      bypass_r <= 3'h0;
      xforce_r <= XF_AUTO;
      ext3_r <= EXT_RST;
      eee_r <= 2'h0;
      ladv_r <= LADV_RST;
      wake_r <= WAKE_RST;
    end else if (do_write) begin
      unique case (waddr_r)
        OFS_MODE: mode_r <= (mode_r & ~wmask[4:0]) | (wdata_r[4:0] & wmask[4:0]);
        OFS_BYPASS: bypass_r <= (bypass_r & ~wmask[2:0]) | (wdata_r[2:0] & wmask[2:0]);
        OFS_XOVER: xforce_r <= (xforce_r & ~wmask[1:0]) | (wdata_r[1:0] & wmask[1:0]);
        OFS_EXT3: ext3_r <= (ext3_r & ~wmask[3:0]) | (wdata_r[3:0] & wmask[3:0]);
        OFS_EEE: eee_r <= (eee_r & ~wmask[1:0]) | (wdata_r[1:0] & wmask[1:0]);
        OFS_LADV: ladv_r <= (ladv_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
        OFS_WAKE: wake_r <= (wake_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]);
        default: ;
      endcase
    end
  end

  // enhanced power enable, nonvolatile default loaded once after reset when power_event_mode is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enh_en_r <= 1'b0;
      nv_loaded_r <= 1'b0;
    end else if (!nv_loaded_r) begin
      nv_loaded_r <= 1'b1;
      enh_en_r <= nv_enh_default && power_event_mode;
    end else if (do_write && waddr_r == OFS_AUX && wstrb_r[0]) begin
      enh_en_r <= wdata_r[AUX_ENH_EN];
    end
  end

  // read value mux
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (araddr[7:0])
      OFS_MODE: rd_val[4:0] = mode_r;
      OFS_BYPASS: rd_val[2:0] = bypass_r;
      OFS_AUX: rd_val[7:0] = {phy_sleep, pol_correct, swap_cd_sel, mdix_sel, enh_en_r};
      OFS_XOVER: rd_val[1:0] = xforce_r;
      OFS_EXT3: rd_val[4:0] = {downshift_r, ext3_r};
      OFS_EEE: rd_val[1:0] = eee_r;
      OFS_LADV: rd_val[15:0] = ladv_r;
      OFS_PADV: rd_val[15:0] = partner_lowpower_advert;
      OFS_WAKE: rd_val[7:0] = wake_r;
      OFS_STAT: rd_val[5:0] = {downshift_r, lpi_enable, link_up, duplex_out, speed_out};
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !rd_take;
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // speed and duplex selection
  always_comb begin
    if (eee_r[EEE_FORCE_GIG] && mode_r[MODE_SPD_LO +: 2] == SPD_1000) begin
      spd_nxt = SPD_1000;
    end else if (!mode_r[MODE_AN_EN]) begin
      spd_nxt = mode_r[MODE_SPD_LO +: 2];
    end else begin
      spd_nxt = an_speed;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_out <= SPD_10;
      duplex_out <= 1'b0;
      gig_forced <= 1'b0;
      power_down <= 1'b0;
    end else begin
      // forced gigabit test mode, no master/slave setup
      gig_forced <= eee_r[EEE_FORCE_GIG] && mode_r[MODE_SPD_LO +: 2] == SPD_1000;
      // fixed speed and duplex with autoneg off
      speed_out <= spd_nxt;
      duplex_out <= mode_r[MODE_AN_EN] ? an_duplex : mode_r[MODE_DUPLEX];
      power_down <= mode_r[MODE_PDOWN];
    end
  end

  // crossover source: auto unless disabled by bypass bits
  always_comb begin
    // bypass bits decide with field at 00b or 01b
    auto_xover = !bypass_r[BYP_DIS_XOVER] &&
                 !(bypass_r[BYP_DIS_XFORCED] && !mode_r[MODE_AN_EN] && spd_nxt != SPD_1000);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdix_sel <= 1'b0;
      swap_cd_sel <= 1'b0;
      pol_correct <= 4'h0;
    end else begin
      if (xforce_r == XF_MDI) begin
        mdix_sel <= 1'b0;
        swap_cd_sel <= 1'b0;
      end else if (xforce_r == XF_MDIX) begin
        mdix_sel <= 1'b1;
        swap_cd_sel <= 1'b0;
      end else begin
        mdix_sel <= auto_xover && xover_detect;
        swap_cd_sel <= auto_xover && cd_swap_detect;
      end
      pol_correct <= bypass_r[BYP_DIS_POL] ? 4'h0 : pair_pol_inv;
    end
  end

  // downshift after failed gigabit attempts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_cnt_r <= 3'h0;
      downshift_r <= 1'b0;
    end else begin
      // counter clears on link or disable
      if (link_up || !ext3_r[EXT_DS_EN]) begin
        fail_cnt_r <= 3'h0;
      end else if (gig_attempt_fail && !downshift_r) begin
        fail_cnt_r <= fail_cnt_r + 3'h1;
      end
      if (partner_gig_capable && pairs_cd_present) begin
        downshift_r <= 1'b0;
      end else if (ext3_r[EXT_IMPAIR_EN] && !pairs_cd_present) begin
        downshift_r <= 1'b1;
      end else if (ext3_r[EXT_DS_EN] && gig_attempt_fail && !link_up && fail_cnt_r + 3'h1 >= ds_limit) begin
        downshift_r <= 1'b1;
      end
    end
  end

  // gigabit advertisement and low power outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_1000 <= 1'b0;
      tx_amp_reduced <= 1'b0;
      lpi_enable <= 1'b0;
    end else begin
      adv_1000 <= !downshift_r;
      tx_amp_reduced <= eee_r[EEE_TEN_TE] && spd_nxt == SPD_10;
      // lpi only at 100 or 1000
      lpi_enable <= link_up && !mode_r[MODE_PDOWN] &&
                    ((spd_nxt == SPD_100 && ladv_r[ADV_100] && partner_lowpower_advert[ADV_100]) ||
                     (spd_nxt == SPD_1000 && ladv_r[ADV_1000] && partner_lowpower_advert[ADV_1000]));
    end
  end

  // enhanced power state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep_r <= EP_ACTIVE;
      tick_r <= 32'h0000_0000;
      units_r <= 8'h00;
      phy_sleep <= 1'b0;
      flp_burst <= 1'b0;
    end else begin
      flp_burst <= 1'b0;
      unique case (ep_r)
        EP_ACTIVE: begin
          tick_r <= 32'h0000_0000;
          units_r <= 8'h00;
          // sleep on no signal, not in deepest suspend
          if (enh_allowed && !signal_detect) begin
            ep_r <= EP_SLEEP;
            phy_sleep <= 1'b1;
          end
        end
        EP_SLEEP: begin
          if (!enh_allowed || signal_detect) begin
            ep_r <= EP_ACTIVE;
            phy_sleep <= 1'b0;
          end else if (tick_r == 32'(TICK_CYC - 1)) begin
            tick_r <= 32'h0000_0000;
            if (units_r + 8'h01 >= wake_r) begin
              units_r <= 8'h00;
              ep_r <= EP_WAKE;
              flp_burst <= 1'b1;
            end else begin
              units_r <= units_r + 8'h01;
            end
          end else begin
            tick_r <= tick_r + 32'h0000_0001;
          end
        end
        EP_WAKE: begin
          ep_r <= (!enh_allowed || signal_detect) ? EP_ACTIVE : EP_SLEEP;
          phy_sleep <= enh_allowed && !signal_detect;
        end
        default: ep_r <= EP_ACTIVE;
      endcase
    end
  end

  // checks
  a_force_gig_speed: assert property (@(posedge aclk) disable iff (!aresetn)
    eee_r[EEE_FORCE_GIG] && mode_r[MODE_SPD_LO +: 2] == SPD_1000 |=> speed_out == SPD_1000 && gig_forced)
    else $error("forced gigabit not applied");
  a_xover_force_mdix: assert property (@(posedge aclk) disable iff (!aresetn)
    xforce_r == XF_MDIX |=> mdix_sel && !swap_cd_sel)
    else $error("forced mdi-x not applied");
  a_xover_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    xforce_r == XF_AUTO && bypass_r[BYP_DIS_XOVER] |=> !mdix_sel)
    else $error("disabled crossover still switching");
  a_pol_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    !bypass_r[BYP_DIS_POL] |=> pol_correct == $past(pair_pol_inv))
    else $error("polarity correction wrong");
  a_downshift_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    downshift_r |=> !adv_1000)
    else $error("gigabit still advertised after downshift");
  a_downshift_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    partner_gig_capable && pairs_cd_present |=> !downshift_r ##1 adv_1000)
    else $error("downshift not left for gigabit partner");
  a_lpi_speed: assert property (@(posedge aclk) disable iff (!aresetn)
    lpi_enable |-> $past(spd_nxt) != SPD_10 && $past(link_up))
    else $error("lpi outside 100/1000");
  a_power_down: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_r[MODE_PDOWN] |=> power_down && !lpi_enable)
    else $error("power down not applied");
  a_sleep_deepest: assert property (@(posedge aclk) disable iff (!aresetn)
    suspend_state == SUSP_DEEPEST |=> !phy_sleep)
    else $error("enhanced sleep in deepest suspend");
  a_burst_sleeping: assert property (@(posedge aclk) disable iff (!aresetn)
    flp_burst |-> phy_sleep ##1 !flp_burst)
    else $error("burst outside sleep");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  c_downshift: cover property (@(posedge aclk) disable iff (!aresetn) $rose(downshift_r));
  c_burst: cover property (@(posedge aclk) disable iff (!aresetn) flp_burst);
  c_force_mdix: cover property (@(posedge aclk) disable iff (!aresetn) $rose(mdix_sel));
  c_lpi: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lpi_enable));

endmodule : phy_link_mode_config

//--- tb/line_partner.sv
// link partner model driving the line side detection inputs
`timescale 1ns/100ps
module line_partner
  import phy_mode_pkg::*;
(
  // bench controls
  input wire logic plugged,
  input wire logic link_en,
  input wire logic gig_cap,
  input wire logic two_pair,
  input wire logic [1:0] wiring,
  input wire logic [3:0] pol_pat,
  input wire logic fail_stb,
  // local gigabit offer seen on the wire
  input wire logic adv_1000,
  // line side results
  output logic signal_detect,
  output logic link_up,
  output logic xover_detect,
  output logic cd_swap_detect,
  output logic [3:0] pair_pol_inv,
  output logic gig_attempt_fail,
  output logic partner_gig_capable,
  output logic pairs_cd_present,
  output logic [1:0] an_speed,
  output logic an_duplex,
  output logic [15:0] partner_lowpower_advert
);
  // energy and detection only while a cable is attached
  assign signal_detect = plugged;
  assign link_up = plugged & link_en;
  assign xover_detect = plugged & wiring[0];
  assign cd_swap_detect = plugged & wiring[1];
  assign pair_pol_inv = plugged ? pol_pat : 4'h0;
  // a failed gigabit try needs energy, no link and a gigabit offer
  assign gig_attempt_fail = fail_stb & plugged & ~link_en & adv_1000;
  assign partner_gig_capable = gig_cap;
  assign pairs_cd_present = ~two_pair;
  // autoneg resolves gigabit only with four pairs and both offers
  assign an_speed = (gig_cap & ~two_pair & adv_1000) ? SPD_1000 : SPD_100;
  assign an_duplex = 1'b1;
  assign partner_lowpower_advert = LADV_RST;
endmodule : line_partner

//--- tb/phy_link_mode_config_tb.sv
// self-checking bench for the phy link mode configuration block
`timescale 1ns/100ps
module phy_link_mode_config_tb
  import phy_mode_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic plugged = 1'b1, link_en = 1'b1, gig_cap = 1'b1, two_pair = 1'b0, fail_stb = 1'b0;
  logic [1:0] wiring = '0, suspend_state = '0;
  logic [3:0] pol_pat = '0;
  logic power_event_mode = 1'b1, nv_enh_default = 1'b1;
  logic signal_detect, link_up, xover_detect, cd_swap_detect, gig_attempt_fail;
  logic partner_gig_capable, pairs_cd_present, an_duplex;
  logic [3:0] pair_pol_inv, pol_correct;
  logic [1:0] an_speed, speed_out;
  logic [15:0] partner_lowpower_advert;
  logic mdix_sel, swap_cd_sel, duplex_out, gig_forced, adv_1000, power_down;
  logic tx_amp_reduced, lpi_enable, phy_sleep, flp_burst;
  int n_fail = 0, num_checks = 0, n_flp = 0, n_cyc = 0;
  logic [31:0] seed = 32'hb838f5e4;
  // {force, bypass, mode, crossed, expected mdi-x}
  logic [11:0] xover_tab [6] = '{{2'h2, 3'h0, 5'h0d, 1'b1, 1'b0}, {2'h3, 3'h0, 5'h0d, 1'b0, 1'b1},
    {2'h0, 3'h1, 5'h0d, 1'b1, 1'b0}, {2'h0, 3'h4, 5'h03, 1'b1, 1'b0}, {2'h0, 3'h4, 5'h0d, 1'b1, 1'b1},
    {2'h1, 3'h0, 5'h0d, 1'b1, 1'b1}};
  // {eee, mode, speed, duplex, forced gig, reduced amplitude}
  logic [11:0] mode_tab [5] = '{{2'h1, 5'h05, 2'h2, 1'b1, 1'b1, 1'b0}, {2'h0, 5'h05, 2'h2, 1'b1, 1'b0, 1'b0},
    {2'h2, 5'h00, 2'h0, 1'b0, 1'b0, 1'b1}, {2'h2, 5'h03, 2'h1, 1'b1, 1'b0, 1'b0},
    {2'h0, 5'h0d, 2'h2, 1'b1, 1'b0, 1'b0}};
  logic [7:0] rst_ofs [7] = '{OFS_MODE, OFS_BYPASS, OFS_XOVER, OFS_EXT3, OFS_EEE, OFS_LADV, OFS_WAKE};
  logic [31:0] rst_val [7] = '{{27'h0, MODE_RST}, 32'h0, 32'h0, {28'h0, EXT_RST}, 32'h0, {16'h0, LADV_RST},
    {24'h0, WAKE_RST}};

  phy_link_mode_config #(.TICK_CYC(4)) DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .signal_detect(signal_detect), .link_up(link_up), .xover_detect(xover_detect),
    .cd_swap_detect(cd_swap_detect), .pair_pol_inv(pair_pol_inv), .gig_attempt_fail(gig_attempt_fail),
    .partner_gig_capable(partner_gig_capable), .pairs_cd_present(pairs_cd_present), .an_speed(an_speed),
    .an_duplex(an_duplex), .partner_lowpower_advert(partner_lowpower_advert), .suspend_state(suspend_state),
    .power_event_mode(power_event_mode), .nv_enh_default(nv_enh_default), .mdix_sel(mdix_sel),
    .swap_cd_sel(swap_cd_sel), .pol_correct(pol_correct), .speed_out(speed_out), .duplex_out(duplex_out),
    .gig_forced(gig_forced), .adv_1000(adv_1000), .power_down(power_down), .tx_amp_reduced(tx_amp_reduced),
    .lpi_enable(lpi_enable), .phy_sleep(phy_sleep), .flp_burst(flp_burst));

  line_partner partner (.plugged(plugged), .link_en(link_en), .gig_cap(gig_cap), .two_pair(two_pair),
    .wiring(wiring), .pol_pat(pol_pat), .fail_stb(fail_stb), .adv_1000(adv_1000),
    .signal_detect(signal_detect), .link_up(link_up), .xover_detect(xover_detect),
    .cd_swap_detect(cd_swap_detect), .pair_pol_inv(pair_pol_inv), .gig_attempt_fail(gig_attempt_fail),
    .partner_gig_capable(partner_gig_capable), .pairs_cd_present(pairs_cd_present), .an_speed(an_speed),
    .an_duplex(an_duplex), .partner_lowpower_advert(partner_lowpower_advert));

  // 40 mhz clock
  always #12.5 aclk = ~aclk;

  // hang guard and wake burst counter
  always @(posedge aclk) begin
    n_cyc++;
    if (flp_burst === 1'b1) n_flp++;
    if (n_cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected crossover and polarity status field of the aux register
  function automatic logic [31:0] exp_aux(input logic [1:0] w, input logic [3:0] p);
    return {25'h0, p, w[1], w[0], 1'b0};
  endfunction : exp_aux

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : cyc

  // write one word and compare the response code
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 0;
    dd = 0;
    do begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd && bvalid));
    chk(bresp, er, "write response");
    bready <= 1'b0;
  endtask : axi_wr

  // read one word and compare the response code
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    bit ad;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    ad = 0;
    do begin
      @(posedge aclk);
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 1'b0;
      end
    end while (!(ad && rvalid));
    d = rdata;
    chk(rresp, er, "read response");
    rready <= 1'b0;
  endtask : axi_rd

  task automatic fail(input int n);
    repeat (n) begin
      @(posedge aclk);
      fail_stb <= 1'b1;
      @(posedge aclk);
      fail_stb <= 1'b0;
    end
  endtask : fail

  task automatic expect_adv(input logic e);
    for (int i = 0; i < 20 && adv_1000 !== e; i++) cyc(1);
    chk(adv_1000, e, "gigabit advertisement");
  endtask : expect_adv

  // main sequence
  initial begin
    logic [31:0] d, v;
    logic [11:0] e;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFS_AUX, RESP_OKAY, d);
    chk(d[AUX_ENH_EN], 1'b1, "nonvolatile default");
    for (int i = 0; i < 7; i++) begin
      axi_rd(rst_ofs[i], RESP_OKAY, d);
      chk(d, rst_val[i], "reset value");
    end
    axi_rd(8'h28, RESP_SLVERR, d);
    chk(d, 32'h0, "unmapped data");
    axi_wr(OFS_STAT, rnd(), RESP_SLVERR);
    axi_wr(OFS_PADV, rnd(), RESP_SLVERR);
    axi_rd(OFS_PADV, RESP_OKAY, d);
    chk(d, {16'h0, LADV_RST}, "partner advert");
    // keep both low power speeds advertised so lpi can be seen later
    v = rnd() | 32'h6;
    axi_wr(OFS_LADV, v, RESP_OKAY);
    axi_rd(OFS_LADV, RESP_OKAY, d);
    chk(d, v & 32'hffff, "local advert");
    axi_wr(OFS_AUX, 32'h0, RESP_OKAY);
    // automatic crossover and polarity over all wirings
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wiring <= i[1:0];
      pol_pat <= v[3:0];
      cyc(2);
      chk(mdix_sel, i[0], "auto mdi-x");
      chk(swap_cd_sel, i[1], "c/d swap");
      chk(pol_correct, v[3:0], "polarity");
      axi_rd(OFS_AUX, RESP_OKAY, d);
      chk(d & 32'h7e, exp_aux(i[1:0], v[3:0]), "aux status");
    end
    for (int i = 0; i < 6; i++) begin
      e = xover_tab[i];
      axi_wr(OFS_XOVER, e[11:10], RESP_OKAY);
      axi_wr(OFS_BYPASS, e[9:7], RESP_OKAY);
      axi_wr(OFS_MODE, e[6:2], RESP_OKAY);
      wiring <= {1'b0, e[1]};
      cyc(2);
      chk(mdix_sel, e[0], "crossover force");
    end
    axi_wr(OFS_BYPASS, 32'h2, RESP_OKAY);
    pol_pat <= 4'hf;
    cyc(2);
    chk(pol_correct, 4'h0, "polarity disabled");
    axi_wr(OFS_BYPASS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      e = mode_tab[i];
      axi_wr(OFS_EEE, e[11:10], RESP_OKAY);
      axi_wr(OFS_MODE, e[9:5], RESP_OKAY);
      cyc(2);
      chk(speed_out, e[4:3], "speed");
      chk(duplex_out, e[2], "duplex");
      chk(gig_forced, e[1], "forced gigabit");
      chk(tx_amp_reduced, e[0], "reduced amplitude");
      chk(lpi_enable, e[4:3] != SPD_10, "lpi speed");
    end
    axi_wr(OFS_MODE, 32'h1d, RESP_OKAY);
    cyc(2);
    chk(power_down, 1'b1, "power down");
    axi_wr(OFS_MODE, 32'h0d, RESP_OKAY);
    cyc(2);
    chk(power_down, 1'b0, "power up");
    // downshift after three fails, counter cleared by a link in between
    axi_wr(OFS_EXT3, 32'h6, RESP_OKAY);
    gig_cap <= 1'b0;
    link_en <= 1'b0;
    fail(2);
    link_en <= 1'b1;
    cyc(2);
    link_en <= 1'b0;
    fail(2);
    cyc(3);
    chk(adv_1000, 1'b1, "count cleared");
    fail(1);
    expect_adv(1'b0);
    axi_rd(OFS_EXT3, RESP_OKAY, d);
    chk(d[EXT_APPLY], 1'b1, "downshift status");
    gig_cap <= 1'b1;
    expect_adv(1'b1);
    axi_wr(OFS_EXT3, 32'h7, RESP_OKAY);
    two_pair <= 1'b1;
    fail(1);
    expect_adv(1'b0);
    two_pair <= 1'b0;
    link_en <= 1'b1;
    expect_adv(1'b1);
    // enhanced sleep with periodic bursts, none in deepest suspend
    axi_wr(OFS_AUX, 32'h1, RESP_OKAY);
    plugged <= 1'b0;
    cyc(3);
    chk(phy_sleep, 1'b1, "sleep");
    n_flp = 0;
    cyc(40);
    chk(n_flp, 2, "wake bursts");
    plugged <= 1'b1;
    cyc(2);
    chk(phy_sleep, 1'b0, "wake");
    suspend_state <= SUSP_DEEPEST;
    plugged <= 1'b0;
    cyc(1);
    n_flp = 0;
    cyc(40);
    chk(phy_sleep, 1'b0, "deepest suspend");
    chk(n_flp, 0, "no bursts");
    give_verdict();
  end
endmodule : phy_link_mode_config_tb
